// ### common/pmc_defines.svh
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// register byte offsets
`define OFF_POWER_CTRL_FIRST 8'h00
`define OFF_POWER_CTRL_SECOND 8'h04
`define OFF_REGULATOR_CONTROL 8'h08
`define OFF_CLOCK_SELECT 8'h0C
`define OFF_PERIPH_ENABLE 8'h10
`define OFF_IRQ_STATUS 8'h14
`define OFF_IRQ_MASK 8'h18
`define OFF_MODE_STATUS 8'h1C

// field positions
`define BIT_CORE_HALT 0
`define BIT_POWER_DOWN 1
`define BIT_DEEP_SLEEP 0
`define BIT_LOW_BIAS_SLEEP 1
`define BIT_REG_OFF_SELECT 0
`define BIT_CLOCK_SOURCE 0
`define BIT_TIMER3 3
`define BIT_TIMER4 4
`define IRQ_SLEEP_WAKE 0
`define IRQ_IDLE_WAKE 1
`define IRQ_SLEEP_REFUSED 2
`define IRQ_RESET_EXIT 3

// encodings and reset values
`define CLK_SRC_FAST_OSC_A 1'b0
`define SLOW_CLOCKED_MASK 8'h18
`define RST_PERIPH_ENABLE 8'hFF
`define RST_IRQ_MASK 4'h0
`define RST_PWR_OUT '{core_clk_en: 1'b1, periph_clk_en: 8'hFF, fast_osc_a_en: 1'b1, fast_osc_b_en: 1'b0, \
   reg_low_bias: 1'b0, core_reg_en: 1'b1, power_nets_on: 1'b1, pin_hold: 1'b0}

`endif

// ### common/pmc_pkg.sv
package pmc_pkg;

   // chip power modes
   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_IDLE,
      MODE_SUSPEND,
      MODE_SNOOZE,
      MODE_STOP,
      MODE_SHUTDOWN
   } mode_t;

   // register selected by the bus address
   typedef enum logic [3:0] {
      SEL_NONE,
      SEL_POWER_CTRL_FIRST,
      SEL_POWER_CTRL_SECOND,
      SEL_REGULATOR_CONTROL,
      SEL_CLOCK_SELECT,
      SEL_PERIPH_ENABLE,
      SEL_IRQ_STATUS,
      SEL_IRQ_MASK,
      SEL_MODE_STATUS
   } reg_sel_t;

   // peripheral wake sources, synchronous levels except cmp0 (edge taken inside)
   typedef struct packed {
      logic usb_port_activity;
      logic timer4_event;
      logic serial_peripheral_port_activity;
      logic two_wire_slave_port_activity;
      logic port_match_event;
      logic comparator0_out;
   } wake_src_t;

   // power, clock and regulator controls toward the chip
   typedef struct packed {
      logic core_clk_en;
      logic [7:0] periph_clk_en;
      logic fast_osc_a_en;
      logic fast_osc_b_en;
      logic reg_low_bias;
      logic core_reg_en;
      logic power_nets_on;
      logic pin_hold;
   } pwr_out_t;

endpackage

// ### design/wake_collector.sv
module wake_collector (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // wake sources
   input pmc_pkg::wake_src_t wake_src,
   // merged wake request
   output logic sleep_wake
);
   import pmc_pkg::*;

   logic cmp_prev, next_cmp_prev;
   logic cmp_fall;

   // comparator history, so only a falling edge counts
   always_comb begin
      next_cmp_prev = wake_src.comparator0_out;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_prev <= 1'b0;
      end else begin
         cmp_prev <= next_cmp_prev;
      end
   end

   // any listed source ends a sleep mode
   assign cmp_fall = cmp_prev & ~wake_src.comparator0_out;
   assign sleep_wake = wake_src.usb_port_activity | wake_src.timer4_event
      | wake_src.serial_peripheral_port_activity | wake_src.two_wire_slave_port_activity
      | wake_src.port_match_event | cmp_fall;

endmodule // wake_collector

// ### design/power_mode_controller.sv
`include "pmc_defines.svh"

module power_mode_controller (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // wake and reset sources
   input pmc_pkg::wake_src_t wake_src,
   input wire logic any_interrupt,
   input wire logic reset_pin_low,
   input wire logic por_event,
   input wire logic other_reset_event,
   // power controls and state
   output pmc_pkg::pwr_out_t pwr_out,
   output pmc_pkg::mode_t mode,
   output logic irq
);
   import pmc_pkg::*;

   logic [1:0] power_ctrl_first, next_power_ctrl_first;
   logic [1:0] power_ctrl_second, next_power_ctrl_second;
   logic regulator_off_select, next_regulator_off_select;
   logic core_clock_source, next_core_clock_source;
   logic [7:0] periph_en, next_periph_en;
   logic [3:0] irq_status, next_irq_status;
   logic [3:0] irq_mask, next_irq_mask;
   logic [31:0] next_prdata;
   logic next_pslverr;
   mode_t next_mode;
   pwr_out_t next_pwr_out;
   reg_sel_t bus_sel;
   logic [31:0] read_word;
   logic [3:0] irq_set;
   logic sleep_wake;
   logic bus_write, bus_read_done, any_reset, pin_or_por;

   function automatic reg_sel_t decode(input logic [7:0] addr);
      case (addr)
         `OFF_POWER_CTRL_FIRST: decode = SEL_POWER_CTRL_FIRST;
         `OFF_POWER_CTRL_SECOND: decode = SEL_POWER_CTRL_SECOND;
         `OFF_REGULATOR_CONTROL: decode = SEL_REGULATOR_CONTROL;
         `OFF_CLOCK_SELECT: decode = SEL_CLOCK_SELECT;
         `OFF_PERIPH_ENABLE: decode = SEL_PERIPH_ENABLE;
         `OFF_IRQ_STATUS: decode = SEL_IRQ_STATUS;
         `OFF_IRQ_MASK: decode = SEL_IRQ_MASK;
         `OFF_MODE_STATUS: decode = SEL_MODE_STATUS;
         default: decode = SEL_NONE;
      endcase
   endfunction

   wake_collector u_wake (
      .pclk(pclk),
      .presetn(presetn),
      .wake_src(wake_src),
      .sleep_wake(sleep_wake)
   );

   // bus phases; zero wait states, so the access edge is the transfer edge
   assign bus_sel = decode(paddr);
   assign bus_write = psel & penable & pwrite;
   assign bus_read_done = psel & penable & ~pwrite;
   assign pready = 1'b1;
   assign any_reset = ~reset_pin_low | por_event | other_reset_event;
   assign pin_or_por = ~reset_pin_low | por_event;
   assign irq = |(irq_status & irq_mask);

   // read multiplexer, upper bits read as zero
   always_comb begin
      read_word = 32'h0000_0000;
      case (bus_sel)
         SEL_POWER_CTRL_FIRST: read_word[1:0] = power_ctrl_first;
         SEL_POWER_CTRL_SECOND: read_word[1:0] = power_ctrl_second;
         SEL_REGULATOR_CONTROL: read_word[`BIT_REG_OFF_SELECT] = regulator_off_select;
         SEL_CLOCK_SELECT: read_word[`BIT_CLOCK_SOURCE] = core_clock_source;
         SEL_PERIPH_ENABLE: read_word[7:0] = periph_en;
         SEL_IRQ_STATUS: read_word[3:0] = irq_status;
         SEL_IRQ_MASK: read_word[3:0] = irq_mask;
         SEL_MODE_STATUS: read_word[2:0] = mode;
         default: read_word = 32'h0000_0000;
      endcase
   end

   // registers and mode sequencing; hardware clears follow firmware writes
   always_comb begin
      next_power_ctrl_first = power_ctrl_first;
      next_power_ctrl_second = power_ctrl_second;
      next_regulator_off_select = regulator_off_select;
      next_core_clock_source = core_clock_source;
      next_periph_en = periph_en;
      next_irq_mask = irq_mask;
      next_irq_status = irq_status;
      next_prdata = prdata;
      next_pslverr = pslverr;
      next_mode = mode;
      irq_set = 4'h0;
      // read data captured in setup so the access edge sees a stable word
      if (psel & ~penable) begin
         next_prdata = read_word;
         next_pslverr = (bus_sel == SEL_NONE);
      end
      if (bus_write) begin
         case (bus_sel)
            SEL_POWER_CTRL_FIRST: next_power_ctrl_first = pwdata[1:0];
            SEL_POWER_CTRL_SECOND: next_power_ctrl_second = pwdata[1:0];
            SEL_REGULATOR_CONTROL: next_regulator_off_select = pwdata[`BIT_REG_OFF_SELECT];
            SEL_CLOCK_SELECT: next_core_clock_source = pwdata[`BIT_CLOCK_SOURCE];
            SEL_PERIPH_ENABLE: next_periph_en = pwdata[7:0];
            SEL_IRQ_MASK: next_irq_mask = pwdata[3:0];
            default: next_mode = mode;
         endcase
      end
      // read clears only the bits that were reported
      if (bus_read_done && bus_sel == SEL_IRQ_STATUS) begin
         next_irq_status = irq_status & ~prdata[3:0];
      end
      case (mode)
         MODE_NORMAL: begin
            if (power_ctrl_first[`BIT_POWER_DOWN]) begin
               // regulator-off select picks shutdown over stop
               next_mode = regulator_off_select ? MODE_SHUTDOWN : MODE_STOP;
            end else if (power_ctrl_second != 2'b00) begin
               if (core_clock_source == `CLK_SRC_FAST_OSC_A) begin
                  next_mode = power_ctrl_second[`BIT_DEEP_SLEEP] ? MODE_SUSPEND : MODE_SNOOZE;
               end else begin
                  // wrong clock source: refuse rather than stop a live clock
                  next_power_ctrl_second = 2'b00;
                  irq_set[`IRQ_SLEEP_REFUSED] = 1'b1;
               end
            end else if (power_ctrl_first[`BIT_CORE_HALT]) begin
               next_mode = MODE_IDLE;
            end
         end
         MODE_IDLE: begin
            if (any_interrupt) begin
               next_mode = MODE_NORMAL;
               next_power_ctrl_first[`BIT_CORE_HALT] = 1'b0;
               irq_set[`IRQ_IDLE_WAKE] = 1'b1;
            end
         end
         MODE_SUSPEND, MODE_SNOOZE: begin
            if (sleep_wake) begin
               next_mode = MODE_NORMAL;
               next_power_ctrl_second = 2'b00;
               irq_set[`IRQ_SLEEP_WAKE] = 1'b1;
            end
         end
         MODE_STOP: begin
            // interrupts are ignored here, only a reset source leaves
            if (any_reset) begin
               next_mode = MODE_NORMAL;
               next_power_ctrl_first = 2'b00;
               irq_set[`IRQ_RESET_EXIT] = 1'b1;
            end
         end
         MODE_SHUTDOWN: begin
            if (pin_or_por) begin
               next_mode = MODE_NORMAL;
               next_power_ctrl_first = 2'b00;
               irq_set[`IRQ_RESET_EXIT] = 1'b1;
            end
         end
         default: next_mode = MODE_NORMAL;
      endcase
      // set wins over a read clear in the same cycle
      next_irq_status = next_irq_status | irq_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_ctrl_first <= 2'b00;
         power_ctrl_second <= 2'b00;
         regulator_off_select <= 1'b0;
         core_clock_source <= `CLK_SRC_FAST_OSC_A;
         periph_en <= `RST_PERIPH_ENABLE;
         irq_status <= 4'h0;
         irq_mask <= `RST_IRQ_MASK;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         mode <= MODE_NORMAL;
      end else begin
         power_ctrl_first <= next_power_ctrl_first;
         power_ctrl_second <= next_power_ctrl_second;
         regulator_off_select <= next_regulator_off_select;
         core_clock_source <= next_core_clock_source;
         periph_en <= next_periph_en;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         mode <= next_mode;
      end
   end

   // power controls follow the next mode so they line up with mode
   always_comb begin
      next_pwr_out = `RST_PWR_OUT;
      next_pwr_out.periph_clk_en = next_periph_en;
      next_pwr_out.fast_osc_b_en = (next_core_clock_source != `CLK_SRC_FAST_OSC_A);
      case (next_mode)
         MODE_IDLE: next_pwr_out.core_clk_en = 1'b0;
         MODE_SUSPEND, MODE_SNOOZE: begin
            next_pwr_out.core_clk_en = 1'b0;
            // only timers 3 and 4 keep a clock, fed from the slow oscillator
            next_pwr_out.periph_clk_en = next_periph_en & `SLOW_CLOCKED_MASK;
            next_pwr_out.fast_osc_a_en = 1'b0;
            next_pwr_out.fast_osc_b_en = 1'b0;
            next_pwr_out.reg_low_bias = (next_mode == MODE_SNOOZE);
         end
         MODE_STOP, MODE_SHUTDOWN: begin
            next_pwr_out.core_clk_en = 1'b0;
            next_pwr_out.periph_clk_en = 8'h00;
            next_pwr_out.fast_osc_a_en = 1'b0;
            next_pwr_out.fast_osc_b_en = 1'b0;
            next_pwr_out.power_nets_on = 1'b0;
            next_pwr_out.pin_hold = 1'b1;
            next_pwr_out.core_reg_en = (next_mode == MODE_STOP);
         end
         default: next_pwr_out.core_clk_en = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_out <= `RST_PWR_OUT;
      end else begin
         pwr_out <= next_pwr_out;
      end
   end

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // idle: core stopped, peripherals keep their clocks
   a_idle_core_halt: assert property (mode == MODE_IDLE |->
      !pwr_out.core_clk_en && pwr_out.periph_clk_en == periph_en)
      else $error("idle clocks wrong");
   a_idle_wake_clear: assert property (mode == MODE_IDLE && any_interrupt |=>
      mode == MODE_NORMAL && !power_ctrl_first[`BIT_CORE_HALT] && irq_status[`IRQ_IDLE_WAKE])
      else $error("idle wake failed");
   // sleep entry guard; a request on the wrong source must never stop a live clock
   a_sleep_refuse: assert property (mode == MODE_NORMAL && power_ctrl_second != 2'b00
      && !power_ctrl_first[`BIT_POWER_DOWN] && core_clock_source != `CLK_SRC_FAST_OSC_A
      |=> mode == MODE_NORMAL && irq_status[`IRQ_SLEEP_REFUSED])
      else $error("sleep entered on wrong clock");
   a_sleep_entry: assert property (mode == MODE_NORMAL && power_ctrl_second != 2'b00
      && !power_ctrl_first[`BIT_POWER_DOWN] && core_clock_source == `CLK_SRC_FAST_OSC_A
      |=> mode == ($past(power_ctrl_second[`BIT_DEEP_SLEEP]) ? MODE_SUSPEND : MODE_SNOOZE))
      else $error("sleep not entered");
   a_sleep_clocks_off: assert property (mode inside {MODE_SUSPEND, MODE_SNOOZE} |->
      !pwr_out.core_clk_en && !pwr_out.fast_osc_a_en && !pwr_out.fast_osc_b_en
      && (pwr_out.periph_clk_en & ~`SLOW_CLOCKED_MASK) == 8'h00)
      else $error("sleep clocks running");
   a_sleep_wake_exit: assert property (mode inside {MODE_SUSPEND, MODE_SNOOZE} && sleep_wake |=>
      mode == MODE_NORMAL && power_ctrl_second == 2'b00 ##1 pwr_out.core_clk_en)
      else $error("sleep wake failed");
   a_sleep_bias: assert property (mode inside {MODE_SUSPEND, MODE_SNOOZE} |->
      pwr_out.reg_low_bias == (mode == MODE_SNOOZE))
      else $error("regulator bias wrong");
   // stop and shutdown
   a_stop_entry: assert property (mode == MODE_NORMAL && power_ctrl_first[`BIT_POWER_DOWN]
      && !regulator_off_select |=> mode == MODE_STOP)
      else $error("stop not entered");
   a_stop_holds: assert property (mode == MODE_STOP && reset_pin_low
      && !por_event && !other_reset_event |=> mode == MODE_STOP && pwr_out.pin_hold && !pwr_out.power_nets_on)
      else $error("stop left without reset");
   a_shutdown_entry: assert property (mode == MODE_NORMAL && power_ctrl_first[`BIT_POWER_DOWN]
      && regulator_off_select |=> mode == MODE_SHUTDOWN)
      else $error("shutdown not entered");
   a_shutdown_exit: assert property (mode == MODE_SHUTDOWN |=>
      (mode == MODE_NORMAL) == $past(pin_or_por))
      else $error("shutdown exit wrong");
   a_core_reg_en: assert property (mode inside {MODE_STOP, MODE_SHUTDOWN} |->
      pwr_out.pin_hold && pwr_out.core_reg_en == (mode == MODE_STOP))
      else $error("core regulator wrong");
   // normal: everything powered, peripherals clocked as firmware enabled them
   a_periph_gate: assert property (mode == MODE_NORMAL |->
      pwr_out.periph_clk_en == periph_en && pwr_out.core_clk_en && pwr_out.power_nets_on && !pwr_out.pin_hold)
      else $error("peripheral gating wrong");

   c_idle_trip: cover property (mode == MODE_IDLE ##1 mode == MODE_NORMAL);
   c_snooze_wake: cover property (mode == MODE_SNOOZE && sleep_wake);
   c_stop_reset: cover property (mode == MODE_STOP ##1 mode == MODE_NORMAL);
   c_shutdown: cover property (mode == MODE_SHUTDOWN);
   c_refused: cover property (irq_status[`IRQ_SLEEP_REFUSED]);

endmodule // power_mode_controller

// ### tb/wake_partner.sv
module wake_partner
   import pmc_pkg::*;
(
   // clock
   input wire logic pclk,
   // bench command: 0 none, 1..6 one wake source, 7 interrupt
   input wire logic [2:0] fire,
   // wake side toward the controller
   output wake_src_t wake_src,
   output logic any_interrupt
);
   timeunit 1ns;
   timeprecision 1ps;

   // one-cycle activity; comparator idles high so a drop is a real fall
   always_ff @(posedge pclk) begin
      wake_src.usb_port_activity <= (fire == 3'd1);
      wake_src.timer4_event <= (fire == 3'd2);
      wake_src.serial_peripheral_port_activity <= (fire == 3'd3);
      wake_src.two_wire_slave_port_activity <= (fire == 3'd4);
      wake_src.port_match_event <= (fire == 3'd5);
      wake_src.comparator0_out <= (fire != 3'd6);
      any_interrupt <= (fire == 3'd7);
   end
endmodule // wake_partner

// ### tb/tb.sv
`include "pmc_defines.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pmc_pkg::*;

   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd, v;
   logic pready, pslverr, err, irq, any_interrupt;
   logic reset_pin_low = 1'b1;
   logic por_event = 1'b0;
   logic other_reset_event = 1'b0;
   logic [2:0] fire = 3'h0;
   wake_src_t wake_src;
   pwr_out_t pwr_out, exp_pwr;
   mode_t mode;
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   int snooze;
   logic [31:0] seed = 32'd30768;
   // firmware-side copies the rule model needs
   logic [7:0] periph_model = 8'hFF;
   logic osc_b_model = 1'b0;

   power_mode_controller i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wake_src(wake_src), .any_interrupt(any_interrupt),
      .reset_pin_low(reset_pin_low), .por_event(por_event), .other_reset_event(other_reset_event),
      .pwr_out(pwr_out), .mode(mode), .irq(irq));
   wake_partner i_wake (.pclk(pclk), .fire(fire), .wake_src(wake_src), .any_interrupt(any_interrupt));

   // free-running clock, 10 ns period
   always #5 pclk = ~pclk;

   function automatic logic [31:0] next_rand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   // rule model of the power controls once a mode has settled
   function automatic pwr_out_t model_pwr(input mode_t m);
      pwr_out_t p;
      p = `RST_PWR_OUT;
      p.periph_clk_en = periph_model;
      p.fast_osc_b_en = osc_b_model;
      if (m != MODE_NORMAL)
         p.core_clk_en = 1'b0;
      if (m inside {MODE_SUSPEND, MODE_SNOOZE, MODE_STOP, MODE_SHUTDOWN}) begin
         p.fast_osc_a_en = 1'b0;
         p.fast_osc_b_en = 1'b0;
         p.periph_clk_en = (m inside {MODE_STOP, MODE_SHUTDOWN}) ? 8'h00 : periph_model & `SLOW_CLOCKED_MASK;
      end
      p.reg_low_bias = (m == MODE_SNOOZE);
      p.power_nets_on = !(m inside {MODE_STOP, MODE_SHUTDOWN});
      p.pin_hold = !p.power_nets_on;
      p.core_reg_en = (m != MODE_SHUTDOWN);
      return p;
   endfunction

   task automatic chk_pwr(input pwr_out_t e);
      total_checks++;
      if (pwr_out !== e) begin
         miscompares++;
         $display("BAD pwr_out expected %h seen %h", e, pwr_out);
      end
   endtask

   // apb transfer; an idle edge first so no signal is driven twice in one step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(n, e, rd);
   endtask

   // bounded wait, then the mode and its modelled power controls are compared
   task automatic wait_mode(input mode_t m);
      int n;
      n = 0;
      while (mode !== m && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk("mode", 32'(m), 32'(mode));
      chk_pwr(model_pwr(m));
   endtask

   // random gap so wakes land at varied distances from entry
   task automatic pulse(input logic [2:0] k);
      repeat (1 + next_rand() % 4) @(posedge pclk); // never zero: fire was just lowered
      fire <= k;
      @(posedge pclk);
      fire <= 3'h0;
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // hang guard, well above the run length
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         $display("BAD timeout expected 0 seen 1");
         conclude();
      end
   end

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      exp_pwr = `RST_PWR_OUT;
      @(posedge pclk);
      chk("pwr_out", 32'(exp_pwr), 32'(pwr_out));
      chk("irq", 32'h0000_0000, 32'(irq));
      rd_chk("mask", `OFF_IRQ_MASK, 32'h0000_0000);
      rd_chk("periph", `OFF_PERIPH_ENABLE, 32'h0000_00FF);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("pslverr", 32'h0000_0001, 32'(err));
      apb(1'b1, `OFF_IRQ_MASK, 32'h0000_000F);
      // idle entry and interrupt wake
      apb(1'b1, `OFF_POWER_CTRL_FIRST, 32'h0000_0001);
      wait_mode(MODE_IDLE);
      chk("core_clk", 32'h0000_0000, 32'(pwr_out.core_clk_en));
      chk("periph_clk", 32'h0000_00FF, 32'(pwr_out.periph_clk_en));
      rd_chk("mode_reg", `OFF_MODE_STATUS, 32'h0000_0001);
      pulse(3'd7);
      wait_mode(MODE_NORMAL);
      rd_chk("ctrl_first", `OFF_POWER_CTRL_FIRST, 32'h0000_0000);
      chk("irq", 32'h0000_0001, 32'(irq));
      rd_chk("status", `OFF_IRQ_STATUS, 32'h0000_0002);
      @(posedge pclk);
      chk("irq", 32'h0000_0000, 32'(irq));
      // both sleep modes, each wake source once
      for (int i = 1; i <= 6; i++) begin
         snooze = i % 2;
         apb(1'b1, `OFF_CLOCK_SELECT, 32'h0000_0000);
         // last deep-sleep pass sets both bits: deep sleep wins
         apb(1'b1, `OFF_POWER_CTRL_SECOND,
            (snooze != 0) ? 32'h0000_0002 : ((i == 6) ? 32'h0000_0003 : 32'h0000_0001));
         wait_mode((snooze != 0) ? MODE_SNOOZE : MODE_SUSPEND);
         exp_pwr = `RST_PWR_OUT;
         exp_pwr.core_clk_en = 1'b0;
         exp_pwr.periph_clk_en = 8'hFF & `SLOW_CLOCKED_MASK;
         exp_pwr.fast_osc_a_en = 1'b0;
         exp_pwr.reg_low_bias = (snooze != 0);
         chk("sleep_pwr", 32'(exp_pwr), 32'(pwr_out));
         pulse(3'(i));
         wait_mode(MODE_NORMAL);
         rd_chk("ctrl_second", `OFF_POWER_CTRL_SECOND, 32'h0000_0000);
         rd_chk("status", `OFF_IRQ_STATUS, 32'h0000_0001);
      end
      // sleep request while on the other oscillator is refused
      apb(1'b1, `OFF_CLOCK_SELECT, 32'h0000_0001);
      osc_b_model = 1'b1;
      rd_chk("clk_sel", `OFF_CLOCK_SELECT, 32'h0000_0001);
      apb(1'b1, `OFF_POWER_CTRL_SECOND, 32'h0000_0001);
      repeat (3) @(posedge pclk);
      chk("mode", 32'(MODE_NORMAL), 32'(mode));
      chk("osc_b", 32'h0000_0001, 32'(pwr_out.fast_osc_b_en));
      chk_pwr(model_pwr(MODE_NORMAL));
      rd_chk("status", `OFF_IRQ_STATUS, 32'h0000_0004);
      apb(1'b1, `OFF_CLOCK_SELECT, 32'h0000_0000);
      osc_b_model = 1'b0;
      // stop: wakes ignored, any reset source exits
      apb(1'b1, `OFF_REGULATOR_CONTROL, 32'h0000_0000);
      apb(1'b1, `OFF_POWER_CTRL_FIRST, 32'h0000_0002);
      wait_mode(MODE_STOP);
      chk("nets", 32'h0000_0000, 32'(pwr_out.power_nets_on));
      chk("pin_hold", 32'h0000_0001, 32'(pwr_out.pin_hold));
      chk("core_reg", 32'h0000_0001, 32'(pwr_out.core_reg_en));
      pulse(3'd7);
      pulse(3'd2);
      repeat (4) @(posedge pclk);
      chk("mode", 32'(MODE_STOP), 32'(mode));
      other_reset_event <= 1'b1;
      @(posedge pclk);
      other_reset_event <= 1'b0;
      wait_mode(MODE_NORMAL);
      rd_chk("status", `OFF_IRQ_STATUS, 32'h0000_0008);
      // shutdown: only the pin or power-on reset exits
      apb(1'b1, `OFF_REGULATOR_CONTROL, 32'h0000_0001);
      apb(1'b1, `OFF_POWER_CTRL_FIRST, 32'h0000_0002);
      wait_mode(MODE_SHUTDOWN);
      chk("core_reg", 32'h0000_0000, 32'(pwr_out.core_reg_en));
      chk("pin_hold", 32'h0000_0001, 32'(pwr_out.pin_hold));
      other_reset_event <= 1'b1;
      @(posedge pclk);
      other_reset_event <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("mode", 32'(MODE_SHUTDOWN), 32'(mode));
      reset_pin_low <= 1'b0;
      @(posedge pclk);
      reset_pin_low <= 1'b1;
      wait_mode(MODE_NORMAL);
      rd_chk("status", `OFF_IRQ_STATUS, 32'h0000_0008);
      // second shutdown, left by a power-on reset this time
      rd_chk("reg_ctrl", `OFF_REGULATOR_CONTROL, 32'h0000_0001);
      apb(1'b1, `OFF_POWER_CTRL_FIRST, 32'h0000_0002);
      wait_mode(MODE_SHUTDOWN);
      por_event <= 1'b1;
      @(posedge pclk);
      por_event <= 1'b0;
      wait_mode(MODE_NORMAL);
      rd_chk("status", `OFF_IRQ_STATUS, 32'h0000_0008);
      // random peripheral gating
      repeat (4) begin
         v = next_rand();
         apb(1'b1, `OFF_PERIPH_ENABLE, {24'h00_0000, v[7:0]});
         repeat (2) @(posedge pclk);
         chk("periph_clk", {24'h00_0000, v[7:0]}, 32'(pwr_out.periph_clk_en));
         periph_model = v[7:0];
         chk_pwr(model_pwr(MODE_NORMAL));
      end
      conclude();
   end
endmodule // tb
